// *** slbist_defines.svh ***
// Shared constants of the serial link self test
`ifndef SLBIST_DEFINES_SVH
`define SLBIST_DEFINES_SVH
`define SLB_FRAME_W      6'd36
`define SLB_CNT_W        8
`define SLB_OFF_CTRL     12'h000
`define SLB_OFF_STAT     12'h004
`define SLB_OFF_BC_ERR   12'h008
`define SLB_OFF_TM_ERR   12'h00C
`define SLB_OFF_IRQ_ST   12'h010
`define SLB_OFF_IRQ_MSK  12'h014
`define SLB_OFF_PAY_ERR  12'h018
`define SLB_CTRL_EN      0
`define SLB_CTRL_CLKSEL  1
`define SLB_CTRL_LTEST   2
`define SLB_CTRL_CLRTM   3
`define SLB_IRQ_ENTER    0
`define SLB_IRQ_EXIT     1
`define SLB_IRQ_ERR      2
`define SLB_SCR_SEED     36'h9_5A5A_5A5A
`endif

// *** slbist_pkg.sv ***
// Types of the serial link self test
package slbist_pkg;
	typedef enum logic [1:0] {SLB_IDLE, SLB_WAIT_LOCK, SLB_CHECK, SLB_DONE} slb_des_state_t;
	typedef logic [35:0] slb_frame_t;
endpackage

// *** slbist_link_if.sv ***
// Link between serializer and deserializer ends
`timescale 1ns/1ps
interface slbist_link_if;
	logic                    fwd_valid;   // Forward frame strobe
	slbist_pkg::slb_frame_t  fwd_frame;   // Scrambled forward frame
	logic                    bc_test_en;  // Back channel test enable
	logic                    bc_clk_sel;  // Back channel clock select
	logic                    bc_valid;    // Back channel frame strobe
	logic                    bc_crc_err;  // Back channel frame crc bad
	logic                    bc_locked;   // Back channel lock seen
	modport ser (output fwd_valid, output fwd_frame, input bc_test_en, input bc_clk_sel,
		input bc_valid, input bc_crc_err, input bc_locked);
	modport des (input fwd_valid, input fwd_frame, output bc_test_en, output bc_clk_sel,
		output bc_valid, output bc_crc_err, output bc_locked);
endinterface

// *** slbist_ser.sv ***
// Serializer end of the serial link self test with apb registers
//
// Functional notes
// - Enter test mode on back channel enable
// - Test mode replaces video with zeros
// - Zeros go through normal scrambling path
// - Host toggles local test bit after enable
// - Test clock from input or oscillator
// - Check crc only once back channel locked
// - Eight bit crc count, cleared on entry
// - Test crc count kept until clear/reentry
// - Far end compares stream bits 1..35 with zeros
// - Far end result high on lock
// - Far end pulses result per bad frame
// - Far end holds result after stop
// - Held result persists until restart/reset
// - Run length set by enable duration
// - Lock valid during whole test run
// - Resume sampled video after test ends
`timescale 1ns/1ps
`include "slbist_defines.svh"
module slbist_ser
(
	input  wire logic                   i_clk,        // 20 MHz clock
	input  wire logic                   i_rst,        // Async reset, high
	input  wire logic                   i_psel,       // APB select
	input  wire logic                   i_penable,    // APB enable
	input  wire logic                   i_pwrite,     // APB direction
	input  wire logic [11:0]            i_paddr,      // APB byte address
	input  wire logic [31:0]            i_pwdata,     // APB write data
	output logic                        o_pready,     // APB ready
	output logic [31:0]                 o_prdata,     // APB read data
	output logic                        o_pslverr,    // APB error
	output logic                        o_irq,        // Level interrupt
	output logic                        o_test_mode,  // Test mode state
	input  wire logic                   i_vid_valid,  // Video word strobe
	input  wire logic [35:0]            i_vid_data,   // Video payload
	slbist_link_if.ser                  link          // Link side
);
	logic        test_ff;         // Test mode state
	logic        locked_ff;       // Back channel lock seen
	logic [7:0]  bc_err_ff;       // Functional crc errors
	logic [7:0]  tm_err_ff;       // Test mode crc errors
	logic        ltest_ff;        // Local test bit
	logic        clksel_ff;       // Clock select copy
	logic [2:0]  irq_st_ff;       // Sticky status
	logic [2:0]  irq_msk_ff;      // Interrupt mask
	logic [35:0] lfsr_ff;         // Scrambler state
	logic        fwd_valid_ff;    // Forward strobe
	logic [35:0] fwd_frame_ff;    // Forward frame
	logic [31:0] prdata_ff;       // Read data
	logic        pready_ff;       // Ready
	logic        pslverr_ff;      // Error
	logic        irq_ff;          // Interrupt
	logic        enter;           // Entry edge
	logic        leave;           // Exit edge
	logic        bc_err_ev;       // Counted crc error
	logic        wr;              // Write access
	logic        rd;              // Read access
	logic        hit;             // Mapped address
	logic [2:0]  nxt_irq_st;      // Next sticky status
	logic [35:0] nxt_lfsr;        // Next scrambler state
	logic [35:0] src;             // Frame source

	assign enter = link.bc_test_en & ~test_ff;
	assign leave = ~link.bc_test_en & test_ff;
	// Errors only meaningful once locked
	assign bc_err_ev = link.bc_valid & link.bc_crc_err & link.bc_locked;
	// Writes land at the access edge that samples ready, as the master expects
	assign wr = i_psel & i_penable & i_pwrite & pready_ff;
	assign rd = i_psel & ~i_penable & ~i_pwrite;
	assign hit = (i_paddr <= `SLB_OFF_PAY_ERR) && (i_paddr[1:0] == 2'h0);

	// Test mode follows back channel enable
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			test_ff <= 1'b0;
		else
			test_ff <= link.bc_test_en;
	end

	// Lock state and clock select copy
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			locked_ff <= 1'b0;
			clksel_ff <= 1'b0;
		end
		else
		begin
			locked_ff <= link.bc_locked;
			clksel_ff <= link.bc_clk_sel;
		end
	end

	// Functional crc counter, saturating
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			bc_err_ff <= 8'h00;
		else if (enter)
			bc_err_ff <= 8'h00;
		else if (bc_err_ev && bc_err_ff != 8'hFF)
			bc_err_ff <= bc_err_ff + 8'h01;
	end

	// Test crc counter; error wins over clear
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			tm_err_ff <= 8'h00;
		else if (enter)
			tm_err_ff <= 8'h00;
		else if (test_ff && bc_err_ev && tm_err_ff != 8'hFF)
			tm_err_ff <= tm_err_ff + 8'h01;
		else if (wr && hit && i_paddr == `SLB_OFF_CTRL && i_pwdata[`SLB_CTRL_CLRTM])
			tm_err_ff <= 8'h00;
	end

	// Local test bit, written by host
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			ltest_ff <= 1'b0;
		else if (wr && i_paddr == `SLB_OFF_CTRL)
			ltest_ff <= i_pwdata[`SLB_CTRL_LTEST];
	end

	// Frame source: video or zeros
	always_comb
	begin
		src = test_ff ? 36'h0_0000_0000 : i_vid_data;
		nxt_lfsr = {lfsr_ff[34:0], lfsr_ff[35] ^ lfsr_ff[24]};
	end

	// Scrambler; zeros share the same path
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			lfsr_ff <= `SLB_SCR_SEED;
			fwd_valid_ff <= 1'b0;
			fwd_frame_ff <= 36'h0_0000_0000;
		end
		else
		begin
			// Test runs at full rate, video only when strobed
			fwd_valid_ff <= test_ff | i_vid_valid;
			if (test_ff | i_vid_valid)
			begin
				lfsr_ff <= nxt_lfsr;
				fwd_frame_ff <= src ^ lfsr_ff;
			end
		end
	end
	assign link.fwd_valid = fwd_valid_ff;
	assign link.fwd_frame = fwd_frame_ff;

	// Sticky events; set beats clear
	always_comb
	begin
		nxt_irq_st = irq_st_ff;
		if (wr && i_paddr == `SLB_OFF_IRQ_ST)
			nxt_irq_st = irq_st_ff & ~i_pwdata[2:0];
		nxt_irq_st[`SLB_IRQ_ENTER] = nxt_irq_st[`SLB_IRQ_ENTER] | enter;
		nxt_irq_st[`SLB_IRQ_EXIT] = nxt_irq_st[`SLB_IRQ_EXIT] | leave;
		nxt_irq_st[`SLB_IRQ_ERR] = nxt_irq_st[`SLB_IRQ_ERR] | bc_err_ev;
	end

	// Interrupt status, mask and output
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			irq_st_ff <= 3'h0;
			irq_msk_ff <= 3'h0;
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_st_ff <= nxt_irq_st;
			if (wr && i_paddr == `SLB_OFF_IRQ_MSK)
				irq_msk_ff <= i_pwdata[2:0];
			irq_ff <= |(nxt_irq_st & irq_msk_ff);
		end
	end

	// APB slave: answer one cycle after setup
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
		else
		begin
			pready_ff <= i_psel & ~i_penable;
			pslverr_ff <= i_psel & ~i_penable & ~hit;
			prdata_ff <= 32'h0000_0000;
			if (rd)
			begin
				case (i_paddr)
					`SLB_OFF_CTRL:    prdata_ff <= {28'h0, 1'b0, ltest_ff, 2'h0};
					`SLB_OFF_STAT:    prdata_ff <= {29'h0, clksel_ff, locked_ff, test_ff};
					`SLB_OFF_BC_ERR:  prdata_ff <= {24'h0, bc_err_ff};
					`SLB_OFF_TM_ERR:  prdata_ff <= {24'h0, tm_err_ff};
					`SLB_OFF_IRQ_ST:  prdata_ff <= {29'h0, irq_st_ff};
					`SLB_OFF_IRQ_MSK: prdata_ff <= {29'h0, irq_msk_ff};
					default:          prdata_ff <= 32'h0000_0000; // Unmapped reads zero
				endcase
			end
		end
	end

	assign o_pready = pready_ff;
	assign o_prdata = prdata_ff;
	assign o_pslverr = pslverr_ff;
	assign o_irq = irq_ff;
	assign o_test_mode = test_ff;
endmodule

// *** slbist_des.sv ***
// Deserializer end of the serial link self test
`timescale 1ns/1ps
`include "slbist_defines.svh"
module slbist_des
(
	input  wire logic        i_clk,                        // 20 MHz clock
	input  wire logic        i_rst,                        // Async reset, high
	input  wire logic        i_self_test_enable_pin,       // Test enable
	input  wire logic        i_self_test_clock_select_pin, // 1 = internal_oscillator
	input  wire logic        i_input_clock_present,        // Video clock seen
	input  wire logic        i_bc_valid,                   // Back channel frame strobe
	input  wire logic        i_bc_crc_err,                 // Inject crc error
	output logic             o_pass,                       // Live and held result
	output logic             o_lock,                       // Forward lock
	output logic [7:0]       o_err_frames,                 // Bad frame count
	slbist_link_if.des       link                          // Link side
);
	slbist_pkg::slb_des_state_t state_ff;  // Checker state
	logic        en_ff;      // Enable registered
	logic        sel_ff;     // Clock select
	logic        lock_ff;    // Lock seen
	logic [35:0] lfsr_ff;    // Descrambler state
	logic        pass_ff;    // Result
	logic        fail_ff;    // Any error this run
	logic [7:0]  cnt_ff;     // Error frames
	logic        bcv_ff;     // Back channel strobe
	logic        bce_ff;     // Back channel crc bad
	logic        bad;        // Payload mismatch
	logic [35:0] dat;        // Descrambled frame

	assign dat = link.fwd_frame ^ lfsr_ff;
	// Payload bits 1..35 only
	assign bad = link.fwd_valid & (|dat[35:1]);

	// Enable, clock select, lock
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			en_ff <= 1'b0;
			sel_ff <= 1'b0;
			lock_ff <= 1'b0;
			bcv_ff <= 1'b0;
			bce_ff <= 1'b0;
		end
		else
		begin
			en_ff <= i_self_test_enable_pin;
			sel_ff <= i_self_test_clock_select_pin | ~i_input_clock_present;
			lock_ff <= 1'b1;
			bcv_ff <= i_bc_valid;
			bce_ff <= i_bc_valid & i_bc_crc_err;
		end
	end
	assign link.bc_test_en = en_ff;
	assign link.bc_clk_sel = sel_ff;
	assign link.bc_locked = lock_ff;
	assign link.bc_valid = bcv_ff;
	assign link.bc_crc_err = bce_ff;

	// Descrambler tracks the serializer
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			lfsr_ff <= `SLB_SCR_SEED;
		else if (link.fwd_valid)
			lfsr_ff <= {lfsr_ff[34:0], lfsr_ff[35] ^ lfsr_ff[24]};
	end

	// Checker state and result output
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff <= slbist_pkg::SLB_IDLE;
			pass_ff <= 1'b1;
			fail_ff <= 1'b0;
			cnt_ff <= 8'h00;
		end
		else
		begin
			case (state_ff)
				slbist_pkg::SLB_IDLE, slbist_pkg::SLB_DONE:
				begin
					if (en_ff)
					begin
						state_ff <= slbist_pkg::SLB_WAIT_LOCK;
						fail_ff <= 1'b0;
						cnt_ff <= 8'h00;
					end
				end
				slbist_pkg::SLB_WAIT_LOCK:
				begin
					if (!en_ff)
						state_ff <= slbist_pkg::SLB_DONE;
					else if (lock_ff && link.fwd_valid)
					begin
						state_ff <= slbist_pkg::SLB_CHECK;
						pass_ff <= 1'b1;
					end
				end
				slbist_pkg::SLB_CHECK:
				begin
					if (!en_ff)
					begin
						state_ff <= slbist_pkg::SLB_DONE;
						pass_ff <= ~fail_ff;
					end
					else if (bad)
					begin
						// One cycle low stands in for half period
						pass_ff <= 1'b0;
						fail_ff <= 1'b1;
						if (cnt_ff != 8'hFF)
							cnt_ff <= cnt_ff + 8'h01;
					end
					else
						pass_ff <= 1'b1;
				end
				default: state_ff <= slbist_pkg::SLB_IDLE;
			endcase
		end
	end

	assign o_pass = pass_ff;
	assign o_lock = lock_ff;
	assign o_err_frames = cnt_ff;
endmodule

// *** slbist_link_chk.sv ***
// Assertions on the link between the two self test ends
`timescale 1ns/1ps
module slbist_link_chk
(
	input  wire logic                   i_clk,      // Clock
	input  wire logic                   i_rst,      // Reset, high
	input  wire logic                   fwd_valid,  // Frame strobe
	input  wire slbist_pkg::slb_frame_t fwd_frame,  // Sent frame
	input  wire logic                   bc_test_en, // Test enable
	input  wire logic                   bc_valid,   // Back frame
	input  wire logic                   bc_crc_err, // Back crc bad
	input  wire logic                   bc_locked   // Back lock
);
	// One clock domain, so one default for all
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Enable lands in the serializer, frames follow one cycle later
	property p_enter; $rose(bc_test_en) |-> ##2 fwd_valid; endproperty
	a_enter: assert property (p_enter) else $error("no frames after entry");
	property p_zero; bc_test_en [*3] |-> fwd_valid; endproperty
	a_zero: assert property (p_zero) else $error("test frames stalled");
	// Zeros leave scrambled, never as plain zeros
	property p_scr; bc_test_en [*3] |-> fwd_frame != '0; endproperty
	a_scr: assert property (p_scr) else $error("frame not scrambled");
	property p_run; bc_test_en [*4] |-> fwd_frame != $past(fwd_frame); endproperty
	a_run: assert property (p_run) else $error("scrambler stuck");
	property p_len; bc_test_en [*2] |=> fwd_valid; endproperty
	a_len: assert property (p_len) else $error("run shorter than enable");
	// Exit takes as long as entry, so video is back two cycles on
	property p_exit; $fell(bc_test_en) |-> ##2 $fell(fwd_valid); endproperty
	a_exit: assert property (p_exit) else $error("test frames after exit");
	property p_lock; bc_test_en [*2] |-> bc_locked; endproperty
	a_lock: assert property (p_lock) else $error("lock lost in test");
	property p_crc; bc_crc_err |-> bc_valid; endproperty
	a_crc: assert property (p_crc) else $error("crc flag without frame");
	c_enter: cover property ($rose(bc_test_en));
	c_exit: cover property ($fell(bc_test_en));
	c_crc: cover property (bc_crc_err);
endmodule

// *** tb_serial_link_bist.sv ***
// Bench: both ends joined, a second checking end fed a corrupted copy
`timescale 1ns/1ps
module tb_serial_link_bist;
	logic        clk = 1'b0;   // 20 MHz clock
	logic        rst = 1'b1;   // Async reset
	logic        psel = 1'b0;  // APB select
	logic        pen = 1'b0;   // APB enable
	logic        pwr = 1'b0;   // APB direction
	logic [11:0] padr = '0;    // APB address
	logic [31:0] pwd = '0;     // APB write data
	logic [31:0] prd, rdat;    // Read data, last taken
	logic        prdy, perr, rerr, irq, tmode;
	logic        vv = 1'b0;    // Video strobe
	logic [35:0] vd = '0;      // Video word
	logic        pin = 1'b0;   // Test enable pin
	logic        csel = 1'b0;  // Clock select pin
	logic        cpres = 1'b1; // Input clock present
	logic        bcv = 1'b0;   // Back frame strobe
	logic        bce = 1'b0;   // Back crc bad
	logic        pass, lock, pass2, lock2;
	logic [7:0]  errf, errf2;  // Bad frame counts
	logic [35:0] flip = '0;    // Corruption on second link only
	int          errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          lowcnt = 0;   // Live low cycles, second end
	slbist_link_if link();
	slbist_link_if link2();
	// Second link copies the first, chosen bits turned over
	assign link2.fwd_valid = link.fwd_valid;
	assign link2.fwd_frame = link.fwd_frame ^ flip;
	always #25 clk = ~clk;
	slbist_ser slbist_ser_i (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_pready(prdy), .o_prdata(prd),
		.o_pslverr(perr), .o_irq(irq), .o_test_mode(tmode), .i_vid_valid(vv),
		.i_vid_data(vd), .link(link.ser));
	slbist_des slbist_des_i (.i_clk(clk), .i_rst(rst), .i_self_test_enable_pin(pin),
		.i_self_test_clock_select_pin(csel), .i_input_clock_present(cpres),
		.i_bc_valid(bcv), .i_bc_crc_err(bce), .o_pass(pass), .o_lock(lock),
		.o_err_frames(errf), .link(link.des));
	slbist_des slbist_des2_i (.i_clk(clk), .i_rst(rst), .i_self_test_enable_pin(pin),
		.i_self_test_clock_select_pin(csel), .i_input_clock_present(cpres),
		.i_bc_valid(bcv), .i_bc_crc_err(bce), .o_pass(pass2), .o_lock(lock2),
		.o_err_frames(errf2), .link(link2.des));
	slbist_link_chk slbist_link_chk_i (.i_clk(clk), .i_rst(rst), .fwd_valid(link.fwd_valid),
		.fwd_frame(link.fwd_frame), .bc_test_en(link.bc_test_en), .bc_valid(link.bc_valid),
		.bc_crc_err(link.bc_crc_err), .bc_locked(link.bc_locked));
	// Hang guard and count of live low cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (pin && pass2 === 1'b0)
			lowcnt <= lowcnt + 1;
		if (cyc == 4000)
		begin
			errors = errors + 1;
			print_verdict();
		end
	end
	task print_verdict;
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer; held until pready, bounded by the hang guard
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (prdy !== 1'b1);
		rdat = prd;
		rerr = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		// Idle edge, so a following call never reassigns psel in this step
		@(posedge clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, '0);
		chk("prdata", rdat, e);
	endtask
	task do_reset;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Lock rises at the first edge after release, seen at the second
		repeat (2) @(posedge clk);
	endtask
	// Back channel frames with bad crc, then time for counts to settle
	task bcerr(input int n);
		repeat (n)
		begin
			bcv <= 1'b1;
			bce <= 1'b1;
			@(posedge clk);
			bcv <= 1'b0;
			bce <= 1'b0;
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask
	task start;
		pin <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task stop;
		pin <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// One corrupted frame on the second link
	task corrupt(input logic [35:0] m);
		flip <= m;
		@(posedge clk);
		flip <= '0;
		repeat (4) @(posedge clk);
	endtask
	task t_regs;
		chk("pass", pass, 1'b1);
		chk("lock", lock, 1'b1);
		rd(12'h004, 32'h0000_0002);
		wr(12'h01C, '1);
		rd(12'h01C, '0);
		chk("slverr", rerr, 1'b1);
		rd(12'h010, '0);
	endtask
	task t_counts;
		logic seen;
		bcerr(2);
		rd(12'h008, 32'h0000_0002);
		rd(12'h00C, '0);
		start();
		chk("mode", tmode, 1'b1);
		rd(12'h008, '0);
		wr(12'h000, 32'h0000_0004);
		rd(12'h000, 32'h0000_0004);
		wr(12'h000, '0);
		rd(12'h000, '0);
		// Logical not keeps the expected bit one wide in a wide context
		for (int i = 0; i < 4; i++)
		begin
			csel <= i[0];
			cpres <= i[1];
			repeat (4) @(posedge clk);
			chk("clksel", link.bc_clk_sel, i[0] | !i[1]);
			rd(12'h004, {29'h0, i[0] | !i[1], 2'b11});
		end
		cpres <= 1'b1;
		bcerr(3);
		rd(12'h008, 32'h0000_0003);
		rd(12'h00C, 32'h0000_0003);
		vv <= 1'b1;
		vd <= '1;
		repeat (10) @(posedge clk);
		vv <= 1'b0;
		repeat (3) @(posedge clk);
		chk("errf", errf, 8'h00);
		chk("pass", pass, 1'b1);
		stop();
		chk("mode", tmode, 1'b0);
		vv <= 1'b1;
		@(posedge clk);
		vv <= 1'b0;
		seen = 1'b0;
		repeat (4) @(posedge clk) seen |= link.fwd_valid;
		chk("video", seen, 1'b1);
		rd(12'h00C, 32'h0000_0003);
		bcerr(1);
		rd(12'h008, 32'h0000_0004);
		rd(12'h00C, 32'h0000_0003);
		wr(12'h000, 32'h0000_0008);
		rd(12'h00C, '0);
		rd(12'h010, 32'h0000_0007);
		// A set mask bit lets its status bit through to the pin
		chk("irq", irq, 1'b0);
		wr(12'h014, 32'h0000_0007);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b1);
		wr(12'h010, 32'h0000_0007);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b0);
		rd(12'h010, '0);
	endtask
	task t_fwd_err;
		int low0;
		start();
		chk("pass2", pass2, 1'b1);
		low0 = lowcnt;
		corrupt(36'h0_0000_0020);
		chk("errf2", errf2, 8'h01);
		chk("low", 36'(lowcnt - low0), 36'h1);
		corrupt(36'h0_0000_0001);
		chk("errf2", errf2, 8'h01);
		corrupt(36'h8_0000_0000);
		chk("errf2", errf2, 8'h02);
		chk("pass2", pass2, 1'b1);
		chk("errf", errf, 8'h00);
		stop();
		chk("pass2", pass2, 1'b0);
		chk("pass", pass, 1'b1);
		repeat (20) @(posedge clk);
		chk("pass2", pass2, 1'b0);
		start();
		chk("pass2", pass2, 1'b1);
		corrupt(36'h0_0000_0100);
		// Held failure must give way to reset
		stop();
		chk("pass2", pass2, 1'b0);
		do_reset();
		chk("pass2", pass2, 1'b1);
		chk("errf2", errf2, 8'h00);
	endtask
	initial
	begin
		do_reset();
		t_regs();
		t_counts();
		t_fwd_err();
		print_verdict();
	end
endmodule
